// ===== rtl/touch_adc_serial_conversion.sv
// serial command decode, conversion sequencing and result shift-out
// Behaviour
// - a command overlapped with the previous result is accepted
// - converter stays powered while the host pauses mid-conversion
// - fifteen clocks per conversion with overlapped commands works
// - result is unsigned straight binary, msb first
// - eight-bit option ends conversion four clocks sooner
// - low power bit one keeps converter powered, zero powers it down between
// - single-ended mode drives panel only during acquisition
// - ratiometric mode drives panel during acquisition and conversion
// - chip select high powers down and abandons the conversion
// - chip select high leaves the reference setting untouched
// - command: start, channel, resolution, reference mode, two power bits
// - input ignored until start bit; resolution bit high means eight bits
// - next command may start every 15th or 11th clock
// - power encodings decoded; reference setting latched as busy rises
`timescale 1ns/1ps

module touch_adc_serial_conversion #(
  parameter int RESULT_BITS = touch_adc_pkg::BITS_12
) (
  input  wire logic                         sys_clk_in,                 // 25 MHz system clock
  input  wire logic                         reset_n_in,                 // async reset, active low
  input  wire logic                         serial_shift_clock_in,      // host serial clock pin
  input  wire logic                         chip_select_n_in,           // host chip select, active low
  input  wire logic                         serial_data_in,             // host command bit
  input  wire logic [RESULT_BITS-1:0]       sample_code_in,             // quantised analog sample
  output logic                              serial_data_out,            // result bit
  output logic                              serial_data_oe_out,         // result pin driven
  output logic                              busy_out,                   // high from end of acquisition to first result bit
  output logic                              busy_oe_out,                // busy pin driven
  output logic [2:0]                        channel_select_out,         // latched channel
  output logic                              reference_mode_select_out,  // latched reference mode
  output touch_adc_pkg::power_status_t      power_status_out            // power and driver state
);

  typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV} seq_state_t;

  logic [1:0] clk_sync;
  logic [1:0] cs_sync;
  logic [1:0] din_sync;
  logic       clk_prev;
  logic [6:0] cmd_shift;
  logic       cmd_active;
  logic [2:0] cmd_count;
  logic [3:0] count;
  logic [3:0] conv_len;
  logic [RESULT_BITS-1:0] result_shift;
  logic       ref_latched;
  touch_adc_pkg::command_t cmd;
  seq_state_t state;

  wire clk_s   = clk_sync[1];
  wire cs_high = cs_sync[1];
  wire din_s   = din_sync[1];
  wire rise    = clk_s & ~clk_prev;
  wire fall    = ~clk_s & clk_prev;

  // start bit seen while no command is shifting; acquisition is never cut short
  wire start_seen = rise & din_s & ~cmd_active & (state != ST_ACQ);
  wire cmd_done   = rise & cmd_active & (cmd_count == 3'(touch_adc_pkg::CMD_BITS - 2));
  wire [7:0] cmd_byte = {cmd_shift, din_s};
  // field decode of the freshly completed byte
  wire touch_adc_pkg::command_t next_cmd = '{
    cmd_byte[touch_adc_pkg::CHANNEL_MSB:touch_adc_pkg::CHANNEL_LSB],
    cmd_byte[touch_adc_pkg::RES_BIT_POS],
    cmd_byte[touch_adc_pkg::REFMODE_BIT_POS],
    touch_adc_pkg::power_mode_t'(cmd_byte[touch_adc_pkg::PSEL_HIGH_POS:touch_adc_pkg::PSEL_LOW_POS])};
  // eight-bit result is four clocks shorter
  wire [3:0] next_len = next_cmd.short_result ? 4'(touch_adc_pkg::BITS_8) : 4'(touch_adc_pkg::BITS_12);
  wire acq_done   = fall & (state == ST_ACQ) & (count == 4'(touch_adc_pkg::ACQ_CLOCKS - 1));
  wire conv_done  = fall & (state == ST_CONV) & (count == conv_len - 4'h1);
  wire converting = (state == ST_CONV) | (state == ST_ACQ);
  // low power bit selects converter always on or auto power-down
  wire adc_keep   = cmd.power[touch_adc_pkg::PSEL_LOW_POS];
  // powered through the whole conversion, however long host pauses
  wire next_adc_on = ~cs_high & (converting | adc_keep);
  wire next_drv = ~cs_high & ((state == ST_ACQ) | ((state == ST_CONV) & ~cmd.reference_mode_select));

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      clk_sync <= 2'h0;
      cs_sync  <= 2'h3;
      din_sync <= 2'h0;
      clk_prev <= 1'b0;
    end
    else
    begin
      clk_sync <= {clk_sync[0], serial_shift_clock_in};
      cs_sync  <= {cs_sync[0], chip_select_n_in};
      din_sync <= {din_sync[0], serial_data_in};
      clk_prev <= clk_s;
    end
  end

  // command receiver runs beside the sequencer, so the
  // next command shifts in while the current result is still going out
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cmd_active <= 1'b0;
      cmd_count  <= 3'h0;
      cmd_shift  <= 7'h00;
      conv_len   <= 4'h0;
      cmd        <= touch_adc_pkg::COMMAND_RESET;
    end
    else if (cs_high)
    begin
      // fields, power bits included, survive deselect
      cmd_active <= 1'b0;
      cmd_count  <= 3'h0;
    end
    else if (start_seen)
    begin
      cmd_active <= 1'b1;
      cmd_count  <= 3'h0;
      cmd_shift  <= 7'h01;
    end
    else if (cmd_done)
    begin
      cmd_active <= 1'b0;
      cmd        <= next_cmd;
      conv_len   <= next_len;
    end
    else if (rise && cmd_active)
    begin
      // command bits taken on rising edges
      cmd_shift <= {cmd_shift[5:0], din_s};
      cmd_count <= cmd_count + 3'h1;
    end
  end

  // sequencer: acquisition then conversion, restarted by each finished command
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state <= ST_IDLE;
      count <= touch_adc_pkg::COUNT_RESET;
    end
    else if (cs_high)
    begin
      state <= ST_IDLE;
      count <= touch_adc_pkg::COUNT_RESET;
    end
    else if (cmd_done)
    begin
      // a command sent too early overrides the conversion still running
      state <= ST_ACQ;
      count <= touch_adc_pkg::COUNT_RESET;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          state <= ST_IDLE;
        end
        ST_ACQ:
        begin
          if (acq_done)
          begin
            state <= ST_CONV;
            count <= touch_adc_pkg::COUNT_RESET;
          end
          else if (fall)
          begin
            count <= count + 4'h1;
          end
        end
        ST_CONV:
        begin
          if (conv_done)
          begin
            state <= ST_IDLE;
          end
          else if (fall)
          begin
            count <= count + 4'h1;
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // output stage: result shifted msb first after falling edges
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      result_shift       <= touch_adc_pkg::RESULT_RESET;
      serial_data_out    <= 1'b0;
      serial_data_oe_out <= 1'b0;
      busy_out           <= 1'b0;
      busy_oe_out        <= 1'b0;
      ref_latched        <= 1'b0;
      channel_select_out <= 3'h0;
      reference_mode_select_out <= 1'b0;
      power_status_out   <= '0;
    end
    else
    begin
      serial_data_oe_out <= ~cs_high;
      busy_oe_out        <= ~cs_high;
      channel_select_out <= cmd.channel_select;
      reference_mode_select_out <= cmd.reference_mode_select;
      power_status_out   <= '{next_adc_on, ref_latched, next_drv, ~cs_high & (state == ST_ACQ)};
      if (cs_high)
      begin
        busy_out        <= 1'b0;
        serial_data_out <= 1'b0;
      end
      else if (acq_done)
      begin
        // straight binary, 8-bit result is the top bits, zero padded
        result_shift <= cmd.short_result
                        ? {sample_code_in[RESULT_BITS-1 -: touch_adc_pkg::BITS_8],
                           {(RESULT_BITS-touch_adc_pkg::BITS_8){1'b0}}}
                        : sample_code_in;
        // reference power latched as busy rises
        busy_out    <= 1'b1;
        ref_latched <= cmd.power[touch_adc_pkg::PSEL_HIGH_POS];
      end
      else if (fall && state == ST_CONV)
      begin
        // each bit updates after a falling edge
        busy_out        <= 1'b0;
        serial_data_out <= result_shift[RESULT_BITS-1];
        result_shift    <= {result_shift[RESULT_BITS-2:0], 1'b0};
      end
      else if (fall && state == ST_IDLE)
      begin
        serial_data_out <= 1'b0;
      end
    end
  end

endmodule : touch_adc_serial_conversion

// ===== rtl/touch_adc_pkg.sv
// constants and carrier types for the touch converter serial sequencer
package touch_adc_pkg;

  // command byte field positions, shifted msb first
  localparam int START_BIT_POS   = 7;
  localparam int CHANNEL_MSB     = 6;
  localparam int CHANNEL_LSB     = 4;
  localparam int RES_BIT_POS     = 3;
  localparam int REFMODE_BIT_POS = 2;
  localparam int PSEL_HIGH_POS   = 1;
  localparam int PSEL_LOW_POS    = 0;

  // conversion framing, in serial clocks after the last command bit
  localparam int ACQ_CLOCKS      = 3;
  localparam int BITS_12         = 12;
  localparam int BITS_8          = 8;
  localparam int CMD_BITS        = 8;

  // reset values
  localparam logic [7:0]  CMD_RESET    = 8'h00;
  localparam logic [11:0] RESULT_RESET = 12'h000;
  localparam logic [3:0]  COUNT_RESET  = 4'h0;

  typedef enum logic [1:0] {
    PWR_AUTO_DOWN = 2'b00,
    PWR_REF_OFF   = 2'b01,
    PWR_ADC_OFF   = 2'b10,
    PWR_ALWAYS    = 2'b11
  } power_mode_t;

  typedef struct packed {
    logic [2:0]  channel_select;
    logic        short_result;
    logic        reference_mode_select;
    power_mode_t power;
  } command_t;

  localparam command_t COMMAND_RESET = '{3'h0, 1'b0, 1'b0, PWR_AUTO_DOWN};

  typedef struct packed {
    logic converter_powered;
    logic reference_powered;
    logic drivers_on;
    logic sampling;
  } power_status_t;

endpackage : touch_adc_pkg

// ===== verif/touch_adc_monitor.sv
// port checks for the serial conversion sequencer
`timescale 1ns/1ps
module touch_adc_monitor (
  input wire logic                         sys_clk_in,                // clock
  input wire logic                         reset_n_in,                // reset
  input wire logic                         chip_select_n_in,          // select
  input wire logic                         busy_out,                  // busy
  input wire logic                         serial_data_oe_out,        // result enable
  input wire logic                         busy_oe_out,               // busy enable
  input wire logic                         reference_mode_select_out, // mode
  input wire touch_adc_pkg::power_status_t power_status_out           // power
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  AST_CS_OFF: assert property ($rose(chip_select_n_in) |-> ##6 !power_status_out.converter_powered && !busy_out)
    else $error("deselect left work running");
  AST_OE_OFF: assert property (chip_select_n_in [*5] |-> !serial_data_oe_out && !busy_oe_out)
    else $error("pins driven while deselected");
  AST_OE_ON: assert property ((!chip_select_n_in) [*5] |-> serial_data_oe_out && busy_oe_out)
    else $error("pins not driven while selected");
  AST_REF_KEEP: assert property ($rose(chip_select_n_in) |-> ##6 power_status_out.reference_powered == $past(power_status_out.reference_powered, 6))
    else $error("deselect changed reference");
  AST_BUSY_LEN: assert property ($rose(busy_out) |-> busy_out [*7] ##[1:2] !busy_out)
    else $error("busy length wrong");
  AST_CONV_PWR: assert property (busy_out |-> power_status_out.converter_powered)
    else $error("converter off while converting");
  AST_SE_DRV: assert property ($fell(busy_out) && reference_mode_select_out |-> !power_status_out.drivers_on)
    else $error("drivers on during single-ended conversion");
  AST_DIFF_DRV: assert property (busy_out && !reference_mode_select_out |-> power_status_out.drivers_on)
    else $error("drivers off during ratiometric conversion");
  AST_ACQ_FIRST: assert property ($rose(busy_out) |-> $past(power_status_out.sampling, 4) && $past(power_status_out.drivers_on, 4))
    else $error("no acquisition before conversion");
  cover property ($rose(busy_out) && reference_mode_select_out);
  cover property ($rose(busy_out) && !reference_mode_select_out);
  cover property ($rose(chip_select_n_in) && power_status_out.converter_powered);
endmodule : touch_adc_monitor

// ===== verif/touch_adc_host_model.sv
// serial master model driving the converter's four-wire port
`timescale 1ns/1ps
module touch_adc_host_model (
  input  wire logic sys_clk_in, // pacing clock
  output logic      sclk_out,   // serial clock
  output logic      cs_n_out,   // chip select
  output logic      din_out,    // command bit
  input  wire logic dout_in     // result bit
);
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    din_out = 1'b0;
  end
  // bits change while clock low; result read late in the high half, where it stands
  task automatic xfer(input logic [63:0] bits, input int n, input int hold_at, output logic [63:0] got);
    got = '0;
    cs_n_out = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    for (int k = 0; k < n; k++)
    begin
      din_out = bits[n-1-k];
      repeat (4) @(negedge sys_clk_in);
      sclk_out = 1'b1;
      repeat (4) @(negedge sys_clk_in);
      got[n-1-k] = dout_in;
      sclk_out = 1'b0;
      // pause for other traffic, far inside the droop limit
      if (k == hold_at) repeat (40) @(negedge sys_clk_in);
    end
    repeat (4) @(negedge sys_clk_in);
    cs_n_out = 1'b1;
    din_out = ~din_out;
    repeat (12) @(negedge sys_clk_in);
  endtask : xfer
endmodule : touch_adc_host_model

// ===== verif/touch_adc_serial_conversion_bench.sv
// self-checking bench for the serial conversion sequencer
`timescale 1ns/1ps
module touch_adc_serial_conversion_bench;
  logic                         sys_clk_in = 1'b0;
  logic                         reset_n_in = 1'b0;
  logic                         sclk, cs_n, din, dout, dout_oe, busy, busy_oe, ref_mode;
  logic [2:0]                   chan;
  logic [11:0]                  code = 12'h000;
  logic [63:0]                  got;
  touch_adc_pkg::power_status_t pwr;
  int                           n_fail = 0;
  int                           comparisons = 0;
  always #20 sys_clk_in = ~sys_clk_in;
  touch_adc_host_model touch_adc_host_model_i (.sys_clk_in(sys_clk_in), .sclk_out(sclk), .cs_n_out(cs_n),
    .din_out(din), .dout_in(dout));
  touch_adc_serial_conversion touch_adc_serial_conversion_i (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .serial_shift_clock_in(sclk), .chip_select_n_in(cs_n), .serial_data_in(din), .sample_code_in(code),
    .serial_data_out(dout), .serial_data_oe_out(dout_oe), .busy_out(busy), .busy_oe_out(busy_oe),
    .channel_select_out(chan), .reference_mode_select_out(ref_mode), .power_status_out(pwr));
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic t_single();
    code = 12'hA5C;
    touch_adc_host_model_i.xfer(64'h0D60000, 28, -1, got);
    check(got[12:1], 12'hA5C);
    check({9'h0, chan}, 12'h005);
    check({11'h0, ref_mode}, 12'h001);
    check({11'h0, pwr.reference_powered}, 12'h001);
    $display("single done");
  endtask : t_single
  task automatic t_eight();
    code = 12'h3C7;
    touch_adc_host_model_i.xfer(64'h558E9000, 31, -1, got);
    check({4'h0, got[19:12]}, 12'h03C);
    check({4'h0, got[8:1]}, 12'h03C);
    check({9'h0, chan}, 12'h006);
    check({11'h0, pwr.reference_powered}, 12'h000);
    $display("eight done");
  endtask : t_eight
  task automatic t_abort();
    code = 12'h123;
    touch_adc_host_model_i.xfer(64'h35C0, 14, -1, got);
    check({9'h0, pwr.converter_powered, pwr.drivers_on, busy}, 12'h000);
    check({10'h0, dout_oe, busy_oe}, 12'h000);
    check({11'h0, pwr.reference_powered}, 12'h001);
    $display("abort done");
  endtask : t_abort
  task automatic t_fifteen();
    code = 12'h801;
    touch_adc_host_model_i.xfer(64'h4980B70000, 39, 19, got);
    check(got[27:16], 12'h801);
    check(got[12:1], 12'h801);
    check({8'h0, chan, ref_mode}, 12'h007);
    $display("fifteen done");
  endtask : t_fifteen
  initial
  begin
    repeat (4) @(negedge sys_clk_in);
    reset_n_in = 1'b1;
    repeat (6) @(negedge sys_clk_in);
    t_single();
    t_eight();
    t_abort();
    t_fifteen();
    complete_run();
  end
  initial
  begin
    #2ms;
    n_fail++;
    complete_run();
  end
endmodule : touch_adc_serial_conversion_bench
bind touch_adc_serial_conversion touch_adc_monitor touch_adc_monitor_i (.sys_clk_in(sys_clk_in),
  .reset_n_in(reset_n_in), .chip_select_n_in(chip_select_n_in), .busy_out(busy_out),
  .serial_data_oe_out(serial_data_oe_out), .busy_oe_out(busy_oe_out),
  .reference_mode_select_out(reference_mode_select_out), .power_status_out(power_status_out));
